// ---- tcl_timer.sv ----
/*
 * tcl_timer: auto-reload timer with split mode, run gate, low-byte
 * overflow flag and interrupt request, behind an AHB-Lite slave.
 * Assumes a single AHB-Lite master, word transfers, and an external
 * oscillator pin that is asynchronous to core_clk.
 */
`timescale 1ns/1ns

// Contract
// - A low-byte step out of 0xff sets the low overflow flag in any mode; only software clears it.
// - With the low interrupt enable and the timer interrupt enable set, a low overflow raises the interrupt request.
// - The two unused control bits read as zero and ignore writes.
// - In split mode the timer is two 8-bit counters, each reloading from its own reload byte.
// - Outside split mode the timer is one 16-bit counter reloading from the 16-bit reload value.
// - In 16-bit mode the run bit halts or enables the whole timer.
// - In split mode the run bit gates only the high byte; the low byte always counts.
// - The external clock select picks the external source, shared by both bytes in split mode.
// - In split mode each byte picks system clock or external source by its own clock select bit; in 16-bit mode the low byte's bit clocks the whole timer.
// - External select zero gives the system clock divided by twelve.
// - External select one gives the external oscillator divided by eight.
module tcl_timer
    import tcl_pkg::*;
#(
    parameter int SYS_DIV = TCL_SYS_DIV,
    parameter int OSC_DIV = TCL_OSC_DIV
)(
    input  wire logic        core_clk,
    input  wire logic        reset,
    input  wire logic        ext_osc_clk,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic        hready,
    input  wire logic [31:0] hwdata,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    output logic             low_irq_req
);
    // ------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------
    generate
        if (SYS_DIV < 2 || SYS_DIV > 255 || OSC_DIV < 1 || OSC_DIV > 255)
        begin : g_bad
            $error("tcl_timer: divider out of range");
        end
    endgenerate

    localparam logic [7:0] SYS_LAST = 8'(SYS_DIV - 1);
    localparam logic [7:0] OSC_LAST = 8'(OSC_DIV - 1);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [7:0]  ctrl_r;
    logic [7:0]  clkctl_r;
    logic [15:0] reload_r;
    logic [15:0] count_r;
    logic        wr_pend_r;
    logic [7:0]  wr_addr_r;
    logic        hreadyout_r;
    logic [31:0] hrdata_r;
    logic        irq_r;
    logic [7:0]  sys_cnt_r;
    logic        sys_tick_r;
    logic [2:0]  osc_sync_r;
    logic [7:0]  osc_cnt_r;
    logic        osc_tick_r;
    logic        ext_tick;
    logic        tick_l;
    logic        tick_h;
    logic        step_l;
    logic        step_h;
    logic        low_wrap;
    logic        full_wrap;
    logic        wr_ctrl;
    logic        wr_clk;
    logic        wr_rel;
    logic        wr_cnt;
    logic        rd_req;
    logic        split;
    logic        run;

    // register read decode, zero for unmapped offsets
    function automatic logic [31:0] reg_read(input logic [7:0] a);
        logic [31:0] v;
        v = 32'h0000_0000;
        unique case (a)
            TCL_OFS_CTRL:   v = {24'h00_0000, ctrl_r};
            TCL_OFS_CLKCTL: v = {24'h00_0000, clkctl_r};
            TCL_OFS_RELOAD: v = {16'h0000, reload_r};
            TCL_OFS_COUNT:  v = {16'h0000, count_r};
            default:        v = 32'h0000_0000;
        endcase
        return v;
    endfunction

    // ------------------------------------------------------------
    // ahb-lite slave
    // ------------------------------------------------------------
    assign rd_req  = hready && hsel && htrans[1] && !hwrite;
    assign wr_ctrl = wr_pend_r && (wr_addr_r == TCL_OFS_CTRL);
    assign wr_clk  = wr_pend_r && (wr_addr_r == TCL_OFS_CLKCTL);
    assign wr_rel  = wr_pend_r && (wr_addr_r == TCL_OFS_RELOAD);
    assign wr_cnt  = wr_pend_r && (wr_addr_r == TCL_OFS_COUNT);

    // address phase capture; sub-word writes are dropped
    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= 8'h00;
        end
        else if (hready)
        begin
            wr_pend_r <= hsel && htrans[1] && hwrite && (hsize == 3'h2);
            wr_addr_r <= {haddr[7:2], 2'b00};
        end
        else
        begin
            wr_pend_r <= 1'b0;
        end
    end

    // zero wait state; read data sampled at the address phase edge
    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            hreadyout_r <= 1'b1;
            hrdata_r    <= 32'h0000_0000;
        end
        else
        begin
            hreadyout_r <= 1'b1;
            if (rd_req)
            begin
                hrdata_r <= reg_read({haddr[7:2], 2'b00});
            end
        end
    end

    assign hreadyout = hreadyout_r;
    assign hresp     = 1'b0;
    assign hrdata    = hrdata_r;

    // ------------------------------------------------------------
    // control registers
    // ------------------------------------------------------------
    assign split = ctrl_r[TCL_B_SPLIT];
    assign run   = ctrl_r[TCL_B_RUN];

    // control bits; unused bits and the high flag position stay zero
    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            ctrl_r <= TCL_RST_CTRL;
        end
        else
        begin
            if (wr_ctrl)
            begin
                ctrl_r[TCL_B_LIRQ_EN] <= hwdata[TCL_B_LIRQ_EN];
                ctrl_r[TCL_B_SPLIT]   <= hwdata[TCL_B_SPLIT];
                ctrl_r[TCL_B_RUN]     <= hwdata[TCL_B_RUN];
                ctrl_r[TCL_B_XCLK]    <= hwdata[TCL_B_XCLK];
            end
            if (low_wrap)
            begin
                ctrl_r[TCL_B_LOW_FLAG] <= 1'b1;
            end
            else if (wr_ctrl && !hwdata[TCL_B_LOW_FLAG])
            begin
                ctrl_r[TCL_B_LOW_FLAG] <= 1'b0;
            end
        end
    end

    // clock selects, timer interrupt enable and reload value
    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            clkctl_r <= TCL_RST_CLKCTL;
            reload_r <= TCL_RST_RELOAD;
        end
        else
        begin
            if (wr_clk)
            begin
                clkctl_r <= {5'b00000, hwdata[2:0]};
            end
            if (wr_rel)
            begin
                reload_r <= hwdata[15:0];
            end
        end
    end

    // ------------------------------------------------------------
    // external clock sources
    // ------------------------------------------------------------
    // free-running divide by twelve of core_clk
    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            sys_cnt_r  <= 8'h00;
            sys_tick_r <= 1'b0;
        end
        else
        begin
            sys_tick_r <= (sys_cnt_r == SYS_LAST);
            sys_cnt_r  <= (sys_cnt_r == SYS_LAST) ? 8'h00 : sys_cnt_r + 8'h01;
        end
    end

    // pin synchronised; edges seen on stages two and three
    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            osc_sync_r <= 3'b000;
            osc_cnt_r  <= 8'h00;
            osc_tick_r <= 1'b0;
        end
        else
        begin
            osc_sync_r <= {osc_sync_r[1:0], ext_osc_clk};
            osc_tick_r <= 1'b0;
            // one tick per eight oscillator edges
            if (osc_sync_r[1] && !osc_sync_r[2])
            begin
                osc_tick_r <= (osc_cnt_r == OSC_LAST);
                osc_cnt_r  <= (osc_cnt_r == OSC_LAST) ? 8'h00 : osc_cnt_r + 8'h01;
            end
        end
    end

    // one external choice shared by both bytes
    assign ext_tick = ctrl_r[TCL_B_XCLK] ? osc_tick_r : sys_tick_r;
    // per-byte system clock or external source
    assign tick_l   = clkctl_r[TCL_B_LSEL] ? 1'b1 : ext_tick;
    assign tick_h   = clkctl_r[TCL_B_HSEL] ? 1'b1 : ext_tick;

    // ------------------------------------------------------------
    // counters
    // ------------------------------------------------------------
    // run gates all in 16-bit mode, high only in split
    assign step_l    = split ? tick_l : (run && tick_l);
    assign step_h    = split && run && tick_h;
    assign low_wrap  = step_l && (count_r[7:0] == 8'hff);
    assign full_wrap = !split && low_wrap && (count_r[15:8] == 8'hff);

    // a software count write wins over a step in the same cycle
    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            count_r <= TCL_RST_COUNT;
        end
        else if (wr_cnt)
        begin
            count_r <= hwdata[15:0];
        end
        else if (split)
        begin
            if (step_l)
            begin
                count_r[7:0] <= low_wrap ? reload_r[7:0] : count_r[7:0] + 8'h01;
            end
            if (step_h)
            begin
                count_r[15:8] <= (count_r[15:8] == 8'hff) ? reload_r[15:8]
                                                          : count_r[15:8] + 8'h01;
            end
        end
        else if (step_l)
        begin
            count_r <= full_wrap ? reload_r : count_r + 16'h0001;
        end
    end

    // gated interrupt request; enable left to software
    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            irq_r <= 1'b0;
        end
        else
        begin
            irq_r <= ctrl_r[TCL_B_LOW_FLAG] && ctrl_r[TCL_B_LIRQ_EN]
                     && clkctl_r[TCL_B_TIRQ_EN];
        end
    end

    assign low_irq_req = irq_r;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    property p_flag_set;
        low_wrap |=> ctrl_r[TCL_B_LOW_FLAG];
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("low flag not set");

    property p_flag_hold;
        ctrl_r[TCL_B_LOW_FLAG] && !wr_ctrl |=> ctrl_r[TCL_B_LOW_FLAG];
    endproperty
    a_flag_hold: assert property (p_flag_hold) else $error("low flag lost");

    property p_irq;
        low_wrap && ctrl_r[TCL_B_LIRQ_EN] && clkctl_r[TCL_B_TIRQ_EN] && !wr_ctrl && !wr_clk
        |=> ##1 low_irq_req;
    endproperty
    a_irq: assert property (p_irq) else $error("irq not raised");

    property p_irq_off;
        !ctrl_r[TCL_B_LIRQ_EN] |=> !low_irq_req;
    endproperty
    a_irq_off: assert property (p_irq_off) else $error("irq while disabled");

    property p_unused;
        rd_req && ({haddr[7:2], 2'b00} == TCL_OFS_CTRL) |=> hrdata[4] == 1'b0 && hrdata[1] == 1'b0;
    endproperty
    a_unused: assert property (p_unused) else $error("unused bit reads one");

    property p_split_reload;
        split && low_wrap && !wr_cnt |=> count_r[7:0] == $past(reload_r[7:0]);
    endproperty
    a_split_reload: assert property (p_split_reload) else $error("low byte no reload");

    property p_full_reload;
        full_wrap && !wr_cnt |=> count_r == $past(reload_r);
    endproperty
    a_full_reload: assert property (p_full_reload) else $error("16-bit no reload");

    property p_halt;
        !split && !run && !wr_cnt |=> $stable(count_r);
    endproperty
    a_halt: assert property (p_halt) else $error("count moved while halted");

    property p_split_gate;
        split && !run && !wr_cnt |=> $stable(count_r[15:8]);
    endproperty
    a_split_gate: assert property (p_split_gate) else $error("high byte ran");

    property p_low_free;
        split && !run && tick_l && !wr_cnt && count_r[7:0] != 8'hff
        |=> count_r[7:0] == $past(count_r[7:0]) + 8'h01;
    endproperty
    a_low_free: assert property (p_low_free) else $error("low byte stopped");

    property p_ext_sel;
        !clkctl_r[TCL_B_LSEL] |-> tick_l == (ctrl_r[TCL_B_XCLK] ? osc_tick_r : sys_tick_r);
    endproperty
    a_ext_sel: assert property (p_ext_sel) else $error("wrong external source");

    property p_sys_div;
        sys_tick_r |=> !sys_tick_r ##11 sys_tick_r;
    endproperty
    a_sys_div: assert property (p_sys_div) else $error("sys divider period");

    property p_osc_div;
        osc_sync_r[1] && !osc_sync_r[2] && osc_cnt_r == OSC_LAST |=> osc_tick_r;
    endproperty
    a_osc_div: assert property (p_osc_div) else $error("osc divider miss");

    property p_osc_pulse;
        osc_tick_r |=> !osc_tick_r;
    endproperty
    a_osc_pulse: assert property (p_osc_pulse) else $error("osc tick too long");
endmodule

// ---- tcl_pkg.sv ----
/*
 * tcl_pkg: register map, field positions, reset values and divider counts
 * for the timer control logic. Assumes word-aligned AHB-Lite access.
 */
package tcl_pkg;
    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] TCL_OFS_CTRL   = 8'h00; // timer_control
    localparam logic [7:0] TCL_OFS_CLKCTL = 8'h04; // clock_control_register
    localparam logic [7:0] TCL_OFS_RELOAD = 8'h08; // 16-bit reload value
    localparam logic [7:0] TCL_OFS_COUNT  = 8'h0c; // count_high_byte:count_low_byte

    // ------------------------------------------------------------
    // timer_control fields
    // ------------------------------------------------------------
    localparam int TCL_B_LOW_FLAG = 6;
    localparam int TCL_B_LIRQ_EN  = 5;
    localparam int TCL_B_SPLIT    = 3;
    localparam int TCL_B_RUN      = 2;
    localparam int TCL_B_XCLK     = 0;

    // clock_control_register fields
    localparam int TCL_B_LSEL     = 0;
    localparam int TCL_B_HSEL     = 1;
    localparam int TCL_B_TIRQ_EN  = 2;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0]  TCL_RST_CTRL   = 8'h00;
    localparam logic [7:0]  TCL_RST_CLKCTL = 8'h00;
    localparam logic [15:0] TCL_RST_RELOAD = 16'h0000;
    localparam logic [15:0] TCL_RST_COUNT  = 16'h0000;

    // ------------------------------------------------------------
    // external clock source dividers and core clock period
    // ------------------------------------------------------------
    localparam int TCL_SYS_DIV = 12;
    localparam int TCL_OSC_DIV = 8;
    localparam int TCL_CLK_NS  = 40;
endpackage

// ---- tb.sv ----
/*
 * tb: self-checking bench for the timer control logic, driving the
 * AHB-Lite register port and the external oscillator pin directly.
 * Assumes the register offsets, field positions and tick dividers of
 * tcl_pkg, and a slave that always answers OKAY.
 */
`timescale 1ns/1ns

`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin num_errors++; \
    $display("CHECK FAILED at %0t: got %h expected %h", $time, (got), (exp)); end end

module tb
    import tcl_pkg::*;
;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic        core_clk;
    logic        reset;
    logic        ext_osc_clk;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic        hreadyout;
    logic        hresp;
    logic [31:0] hrdata;
    logic        low_irq_req;
    wire logic   hready = hreadyout;
    int          num_errors = 0;
    int          n_checks = 0;
    int          cyc = 0;
    logic [31:0] rd_a;
    logic [31:0] rd_b;
    logic [15:0] s_val;
    logic [15:0] r_val;
    logic        sp;
    int          hi_cnt;

    tcl_timer #(
        .SYS_DIV (TCL_SYS_DIV),
        .OSC_DIV (TCL_OSC_DIV)
    ) uut (
        .core_clk    (core_clk),
        .reset       (reset),
        .ext_osc_clk (ext_osc_clk),
        .hsel        (hsel),
        .haddr       (haddr),
        .htrans      (htrans),
        .hwrite      (hwrite),
        .hsize       (hsize),
        .hready      (hready),
        .hwdata      (hwdata),
        .hreadyout   (hreadyout),
        .hresp       (hresp),
        .hrdata      (hrdata),
        .low_irq_req (low_irq_req)
    );

    // ------------------------------------------------------------
    // clock, watchdog and verdict
    // ------------------------------------------------------------
    initial
    begin
        core_clk = 1'b0;
        forever #(TCL_CLK_NS / 2) core_clk = ~core_clk;
    end

    task automatic finish_test();
        if (num_errors == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // whole run needs under two thousand cycles; ceiling leaves wide margin
    always @(posedge core_clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            num_errors++;
            $display("CHECK FAILED at %0t: run did not complete", $time);
            finish_test();
        end
    end

    // ------------------------------------------------------------
    // bus tasks and expectation helpers
    // ------------------------------------------------------------
    // waits for hready at an edge; the watchdog ends a stuck bus
    task automatic bus_wait();
        @(posedge core_clk);
        while (hready !== 1'b1)
            @(posedge core_clk);
    endtask

    task automatic ahb_write(input logic [7:0] a, input logic [31:0] d);
        hsel   <= 1'b1;
        haddr  <= {24'h000000, a};
        htrans <= 2'b10;
        hwrite <= 1'b1;
        hsize  <= 3'h2;
        bus_wait();
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        bus_wait();
    endtask

    task automatic ahb_read(input logic [7:0] a, output logic [31:0] d);
        hsel   <= 1'b1;
        haddr  <= {24'h000000, a};
        htrans <= 2'b10;
        hwrite <= 1'b0;
        hsize  <= 3'h2;
        bus_wait();
        hsel   <= 1'b0;
        htrans <= 2'b00;
        bus_wait();
        d = hrdata;
    endtask

    // rising edges on the oscillator pin, well under half the core rate
    task automatic osc_pulses(input int n);
        repeat (n)
        begin
            ext_osc_clk <= 1'b1;
            repeat (3) @(posedge core_clk);
            ext_osc_clk <= 1'b0;
            repeat (3) @(posedge core_clk);
        end
    endtask

    function automatic logic [31:0] ctl(logic lirq, logic split, logic run, logic xclk);
        return {26'h0, lirq, 1'b0, split, run, 1'b0, xclk};
    endfunction

    // two counting steps, 16-bit or high byte only
    function automatic logic [15:0] two_steps(logic split, logic [15:0] s, logic [15:0] r);
        logic [15:0] c;
        c = s;
        repeat (2)
            if (split)
                c[15:8] = (c[15:8] == 8'hff) ? r[15:8] : c[15:8] + 8'h01;
            else
                c = (c == 16'hffff) ? r : c + 16'h0001;
        return c;
    endfunction

    // run gate open for exactly n cycles: write spacing is 2 + gap
    task automatic run_window(input logic split, input logic xclk, input int gap);
        ahb_write(TCL_OFS_CTRL, ctl(1'b0, split, 1'b1, xclk));
        repeat (gap) @(posedge core_clk);
        ahb_write(TCL_OFS_CTRL, ctl(1'b0, split, 1'b0, xclk));
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        reset = 1'b1;
        ext_osc_clk = 1'b0;
        hsel = 1'b0;
        haddr = 32'h00000000;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h00000000;
        void'($urandom(41440));
        repeat (5) @(posedge core_clk);
        reset <= 1'b0;
        @(posedge core_clk);
        // register reset values, then unused bits and unmapped space
        ahb_read(TCL_OFS_CTRL, rd_a);   `CHK(rd_a, 32'h00000000)
        ahb_read(TCL_OFS_CLKCTL, rd_a); `CHK(rd_a, 32'h00000000)
        ahb_read(TCL_OFS_RELOAD, rd_a); `CHK(rd_a, 32'h00000000)
        ahb_read(TCL_OFS_COUNT, rd_a);  `CHK(rd_a, 32'h00000000)
        ahb_write(TCL_OFS_CTRL, 32'hffffffff);
        ahb_read(TCL_OFS_CTRL, rd_a);   `CHK(rd_a, 32'h0000002d)
        ahb_write(8'h10, 32'hffffffff);
        ahb_read(8'h10, rd_a);          `CHK(rd_a, 32'h00000000)
        `CHK(hresp, 1'b0)
        // external source: oscillator over eight, 64 edges give 8 steps
        ahb_write(TCL_OFS_CTRL, ctl(1'b0, 1'b0, 1'b0, 1'b1));
        ahb_write(TCL_OFS_COUNT, 32'h00000100);
        ahb_write(TCL_OFS_CTRL, ctl(1'b0, 1'b0, 1'b1, 1'b1));
        osc_pulses(64);
        repeat (10) @(posedge core_clk);
        ahb_write(TCL_OFS_CTRL, ctl(1'b0, 1'b0, 1'b0, 1'b1));
        ahb_read(TCL_OFS_COUNT, rd_a);  `CHK(rd_a, 32'h00000108)
        // split mode: one oscillator source drives both bytes
        ahb_write(TCL_OFS_CTRL, ctl(1'b0, 1'b1, 1'b0, 1'b1));
        ahb_write(TCL_OFS_COUNT, 32'h00002010);
        ahb_write(TCL_OFS_CTRL, ctl(1'b0, 1'b1, 1'b1, 1'b1));
        osc_pulses(64);
        repeat (10) @(posedge core_clk);
        ahb_write(TCL_OFS_CTRL, ctl(1'b0, 1'b1, 1'b0, 1'b1));
        ahb_read(TCL_OFS_COUNT, rd_a);  `CHK(rd_a, 32'h00002818)
        // system clock over twelve: 120-cycle window gives 10 steps
        ahb_write(TCL_OFS_CTRL, ctl(1'b0, 1'b0, 1'b0, 1'b0));
        ahb_write(TCL_OFS_COUNT, 32'h00000100);
        run_window(1'b0, 1'b0, 118);
        ahb_read(TCL_OFS_COUNT, rd_a);  `CHK(rd_a, 32'h0000010a)
        // 16-bit halted: core-clock ticks but run clear, count holds
        ahb_write(TCL_OFS_CLKCTL, 32'h00000003);
        ahb_read(TCL_OFS_COUNT, rd_a);  `CHK(rd_a, 32'h0000010a)
        ahb_read(TCL_OFS_COUNT, rd_b);  `CHK(rd_b, rd_a)
        // split with run clear: low steps each cycle, high holds
        ahb_write(TCL_OFS_CTRL, ctl(1'b0, 1'b1, 1'b0, 1'b0));
        ahb_write(TCL_OFS_COUNT, 32'h00001200);
        ahb_read(TCL_OFS_COUNT, rd_a);  `CHK(rd_a, 32'h00001200)
        ahb_read(TCL_OFS_COUNT, rd_b);
        `CHK(rd_b, rd_a + 32'h00000002)
        `CHK(rd_b[15:8], 8'h12)
        // random reload and start values, 2-cycle run windows, both modes
        for (int i = 0; i < 10; i++)
        begin
            sp = i[0];
            s_val = 16'($urandom);
            r_val = 16'($urandom);
            if (i[1])
                s_val = s_val | 16'hfffe;
            // low byte on a silent source so split results are exact
            ahb_write(TCL_OFS_CLKCTL, sp ? 32'h00000002 : 32'h00000001);
            ahb_write(TCL_OFS_CTRL, ctl(1'b0, sp, 1'b0, 1'b1));
            ahb_write(TCL_OFS_RELOAD, {16'h0000, r_val});
            ahb_write(TCL_OFS_COUNT, {16'h0000, s_val});
            run_window(sp, 1'b1, 0);
            ahb_read(TCL_OFS_COUNT, rd_a);
            `CHK(rd_a[15:0], two_steps(sp, s_val, r_val))
        end
        // low-byte overflow flag and interrupt request with enables
        // low enable only ever set while in split mode
        ahb_write(TCL_OFS_RELOAD, 32'h00000000);
        ahb_write(TCL_OFS_CLKCTL, 32'h00000005);
        ahb_write(TCL_OFS_CTRL, ctl(1'b1, 1'b1, 1'b0, 1'b1));
        ahb_write(TCL_OFS_COUNT, 32'h000000f8);
        hi_cnt = 0;
        // polled mid-cycle so the request is looked at once settled
        while (low_irq_req !== 1'b1 && hi_cnt < 40)
        begin
            @(negedge core_clk);
            hi_cnt++;
        end
        `CHK(low_irq_req, 1'b1)
        @(posedge core_clk);
        ahb_read(TCL_OFS_CTRL, rd_a);   `CHK(rd_a, 32'h00000069)
        repeat (20) @(posedge core_clk);
        ahb_read(TCL_OFS_CTRL, rd_a);   `CHK(rd_a, 32'h00000069)
        ahb_write(TCL_OFS_CTRL, ctl(1'b1, 1'b1, 1'b0, 1'b1));
        ahb_read(TCL_OFS_CTRL, rd_a);   `CHK(rd_a, 32'h00000029)
        `CHK(low_irq_req, 1'b0)
        // each enable cleared in turn: flag still sets, no request
        for (int k = 0; k < 2; k++)
        begin
            // low enable dropped first so no stale request leaks into the window
            ahb_write(TCL_OFS_CTRL, ctl(1'b0, 1'b1, 1'b0, 1'b1));
            ahb_write(TCL_OFS_CLKCTL, k ? 32'h00000005 : 32'h00000001);
            ahb_write(TCL_OFS_CTRL, ctl(k == 0, 1'b1, 1'b0, 1'b1));
            hi_cnt = 0;
            repeat (300)
            begin
                @(negedge core_clk);
                if (low_irq_req !== 1'b0)
                    hi_cnt++;
            end
            `CHK(hi_cnt, 0)
            @(posedge core_clk);
            ahb_read(TCL_OFS_CTRL, rd_a);
            `CHK(rd_a[6], 1'b1)
        end
        finish_test();
    end
endmodule
